// ===== include/desc_cmdsts_pkg.sv
// constants and types for the descriptor command/status block
package desc_cmdsts_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] LAST_WB_OFFSET = 8'h08;
    localparam int CTRL_LEGACY_BIT = 0;
    localparam int CTRL_XRETRY_BIT = 1;
    localparam int CTRL_CSI_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // ------------------------------------------------------------
    // descriptor layout in system memory
    // ------------------------------------------------------------
    localparam logic [7:0] DESC_LINK_OFS = 8'h00;
    localparam logic [7:0] DESC_CMDSTS_OFS = 8'h04;
    localparam logic [7:0] DESC_BUFPTR_OFS = 8'h08;
    localparam logic [7:0] DESC_LEGACY_COUNT_OFS = 8'h08;
    localparam logic [7:0] DESC_LEGACY_BUFPTR_OFS = 8'h0C;

    // ------------------------------------------------------------
    // command/status word fields
    // ------------------------------------------------------------
    localparam int OWN_BIT = 31;
    localparam int MORE_BIT = 30;
    localparam int IRQ_REQ_BIT = 29;
    localparam int CRC_BIT = 28;
    localparam int OK_BIT = 27;
    localparam int ABORT_BIT = 26;
    localparam int UNDERRUN_BIT = 25;
    localparam int CARRIER_BIT = 24;
    localparam int DEFERRED_BIT = 23;
    localparam int EXCESS_DEFER_BIT = 22;
    localparam int LATE_COLL_BIT = 21;
    localparam int EXCESS_COLL_BIT = 20;
    localparam int TALLY_LSB = 16;
    localparam int SIZE_W = 12;
    localparam int RX_STATUS_W = 11;

    // ------------------------------------------------------------
    // collision and deferral limits
    // ------------------------------------------------------------
    localparam int COLL_W = 7;
    localparam logic [6:0] COLL_PER_EXCESS = 7'h10;
    localparam logic [6:0] EXCESS_LIMIT_STD = 7'h10;
    localparam logic [6:0] EXCESS_LIMIT_EXT = 7'h40;
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int DEFER_LIMIT_NS = 3200000;
    localparam int DEFER_LIMIT_CYCLES = DEFER_LIMIT_NS / CLOCK_PERIOD_NS;
    localparam int DEFER_CNT_W = 17;

    // ------------------------------------------------------------
    // carriers and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic is_tx;
        logic [31:0] cmdsts;
        logic [31:0] word2;
        logic [31:0] word3;
    } desc_in_t;

    typedef struct packed {
        logic valid;
        logic is_tx;
        logic owned;
        logic last;
        logic descriptor_irq_request;
        logic crc_append_inhibit;
        logic [SIZE_W-1:0] byte_count;
        logic [31:0] buf_ptr;
    } desc_info_t;

    typedef struct packed {
        logic start;
        logic done;
        logic collision;
        logic defer;
        logic underrun;
        logic carrier_lost;
        logic late_collision;
        logic abort;
    } tx_event_t;

    typedef enum logic {WB_IDLE, WB_PEND} wb_state_t;

    typedef struct packed {
        logic legacy_layout_select;
        logic extended_retry_mode;
        logic carrier_ignore;
        desc_info_t fetch;
        logic [31:0] tx_cmd;
        logic [31:0] rx_cmd;
        logic tx_active;
        logic [COLL_W-1:0] coll_cnt;
        logic [DEFER_CNT_W-1:0] defer_cnt;
        logic tx_deferred_flag;
        logic excess_deferral_flag;
        logic tx_fifo_underrun_flag;
        logic carrier_lost_flag;
        logic late_collision_flag;
        logic tx_aborted_flag;
        wb_state_t wb;
        logic [31:0] wb_word;
        logic wb_is_tx;
        logic irq;
        logic [31:0] last_wb;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

endpackage

// ===== design/desc_cmdsts.sv
// descriptor command/status decode, transmit status build and write-back
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// What this block does
// - one descriptor always covers one buffer fragment
// - legacy layout: pointer at 0Ch, ignore 08h
// - bit 31 ownership: producer sets, consumer clears
// - transmit: driver produces; receive: device produces
// - bit 30 more; transmit status only in last, receive status in every write-back
// - bit 29 requests interrupt on ownership return
// - transmit bit 28 inhibits crc append
// - receive write-back always sets bit 28
// - bits 11-0 byte count, 15-12 reserved
// - bit 26 marks aborted transmission
// - bit 25 marks transmit fifo underrun
// - bit 24 carrier lost unless ignore set
// - bit 23 marks deferred transmission
// - bit 22 marks deferral beyond 3.2 ms
// - bit 21 marks out of window collision
// - bit 20 after 16, or 64 extended
// - standard retry: bits 19-16 count collisions
// - extended: excess events, multiple, single flags
// - default layout: link 0, cmdsts 4, pointer 8
// ----------------------------------------------------------------
module desc_cmdsts #(
    parameter int DEFER_LIMIT = desc_cmdsts_pkg::DEFER_LIMIT_CYCLES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // apb register port
    input wire desc_cmdsts_pkg::apb_req_t i_apb,
    output desc_cmdsts_pkg::apb_rsp_t o_apb,
    // fetched descriptor words from the transfer engine
    input wire logic i_desc_valid,
    input wire desc_cmdsts_pkg::desc_in_t i_desc,
    output desc_cmdsts_pkg::desc_info_t o_fetch,
    // transmit mac events
    input wire desc_cmdsts_pkg::tx_event_t i_tx_ev,
    output logic o_tx_done_ready,
    // receive completion
    input wire logic i_rx_done,
    input wire logic [10:0] i_rx_status,
    input wire logic [11:0] i_rx_size,
    output logic o_rx_done_ready,
    // cmdsts write-back to memory
    output logic o_wb_valid,
    output logic o_wb_is_tx,
    output logic [31:0] o_wb_word,
    input wire logic i_wb_ready,
    output logic o_desc_irq
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DEFER_LIMIT < 1 || DEFER_LIMIT >= (1 << desc_cmdsts_pkg::DEFER_CNT_W)) begin : g_bad_limit
        $error("deferral limit does not fit the counter");
    end

    localparam logic [desc_cmdsts_pkg::DEFER_CNT_W-1:0] LIMIT =
        desc_cmdsts_pkg::DEFER_CNT_W'(DEFER_LIMIT);

    desc_cmdsts_pkg::state_t s_r;
    desc_cmdsts_pkg::state_t s_nxt;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // collision field in both encodings
    function automatic logic [3:0] tally(input logic [6:0] cnt, input logic xretry);
        logic [6:0] rem;
        logic [6:0] events;
        rem = cnt % desc_cmdsts_pkg::COLL_PER_EXCESS;
        events = cnt / desc_cmdsts_pkg::COLL_PER_EXCESS;
        if (xretry) begin
            tally = {events[1:0], rem > 7'h01, rem == 7'h01};
        end else begin
            tally = cnt[3:0];
        end
    endfunction

    // excessive collision threshold per retry mode
    function automatic logic coll_excess(input logic [6:0] cnt, input logic xretry);
        if (xretry) begin
            coll_excess = cnt >= desc_cmdsts_pkg::EXCESS_LIMIT_EXT;
        end else begin
            coll_excess = cnt >= desc_cmdsts_pkg::EXCESS_LIMIT_STD;
        end
    endfunction

    // ------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------
    // a new completion is taken only with no write-back pending
    assign o_tx_done_ready = (s_r.wb == desc_cmdsts_pkg::WB_IDLE);
    assign o_rx_done_ready = (s_r.wb == desc_cmdsts_pkg::WB_IDLE) && !i_tx_ev.done;
    assign o_wb_valid = (s_r.wb == desc_cmdsts_pkg::WB_PEND);
    assign o_wb_is_tx = s_r.wb_is_tx;
    assign o_wb_word = s_r.wb_word;
    assign o_desc_irq = s_r.irq;
    assign o_fetch = s_r.fetch;
    assign o_apb.prdata = s_r.prdata;
    assign o_apb.pready = i_apb.psel && i_apb.penable;
    assign o_apb.pslverr = s_r.pslverr;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] w;
        logic setup;
        logic wr;
        logic mapped;
        logic [6:0] cnt_inc;
        w = 32'h0000_0000;
        setup = i_apb.psel && !i_apb.penable;
        wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
        mapped = (i_apb.paddr == desc_cmdsts_pkg::CTRL_OFFSET) ||
                 (i_apb.paddr == desc_cmdsts_pkg::STATUS_OFFSET) ||
                 (i_apb.paddr == desc_cmdsts_pkg::LAST_WB_OFFSET);
        cnt_inc = s_r.coll_cnt + 7'h01;
        s_nxt = s_r;
        s_nxt.irq = 1'b0;
        s_nxt.fetch.valid = 1'b0;

        // apb: read data and error latched in setup, write at access
        if (setup) begin
            s_nxt.pslverr = !mapped;
            unique case (i_apb.paddr)
                desc_cmdsts_pkg::CTRL_OFFSET: begin
                    s_nxt.prdata = {29'h0, s_r.carrier_ignore, s_r.extended_retry_mode, s_r.legacy_layout_select};
                end
                desc_cmdsts_pkg::STATUS_OFFSET: begin
                    s_nxt.prdata = {16'h0000, s_r.tx_active, s_r.wb == desc_cmdsts_pkg::WB_PEND,
                                    s_r.tx_aborted_flag, s_r.tx_fifo_underrun_flag, s_r.carrier_lost_flag,
                                    s_r.tx_deferred_flag, s_r.excess_deferral_flag, s_r.late_collision_flag,
                                    1'b0, s_r.coll_cnt};
                end
                desc_cmdsts_pkg::LAST_WB_OFFSET: begin
                    s_nxt.prdata = s_r.last_wb;
                end
                default: begin
                    s_nxt.prdata = 32'h0000_0000;
                end
            endcase
        end
        if (wr && i_apb.paddr == desc_cmdsts_pkg::CTRL_OFFSET) begin
            s_nxt.legacy_layout_select = i_apb.pwdata[desc_cmdsts_pkg::CTRL_LEGACY_BIT];
            s_nxt.extended_retry_mode = i_apb.pwdata[desc_cmdsts_pkg::CTRL_XRETRY_BIT];
            s_nxt.carrier_ignore = i_apb.pwdata[desc_cmdsts_pkg::CTRL_CSI_BIT];
        end

        // descriptor decode: one fragment, one pointer
        if (i_desc_valid) begin
            s_nxt.fetch.valid = 1'b1;
            s_nxt.fetch.is_tx = i_desc.is_tx;
            // tx: device consumes when set; rx: device fills when clear
            s_nxt.fetch.owned = i_desc.is_tx ? i_desc.cmdsts[desc_cmdsts_pkg::OWN_BIT] :
                                               !i_desc.cmdsts[desc_cmdsts_pkg::OWN_BIT];
            s_nxt.fetch.last = !i_desc.cmdsts[desc_cmdsts_pkg::MORE_BIT];
            s_nxt.fetch.descriptor_irq_request = i_desc.cmdsts[desc_cmdsts_pkg::IRQ_REQ_BIT];
            s_nxt.fetch.crc_append_inhibit = i_desc.is_tx && i_desc.cmdsts[desc_cmdsts_pkg::CRC_BIT];
            s_nxt.fetch.byte_count = i_desc.cmdsts[desc_cmdsts_pkg::SIZE_W-1:0];
            // legacy count word is never looked at
            s_nxt.fetch.buf_ptr = s_r.legacy_layout_select ? i_desc.word3 : i_desc.word2;
            if (i_desc.is_tx) begin
                s_nxt.tx_cmd = i_desc.cmdsts;
            end else begin
                s_nxt.rx_cmd = i_desc.cmdsts;
            end
        end

        // transmit events: a start clears, an event in the same cycle still sets
        if (i_tx_ev.start) begin
            s_nxt.tx_active = 1'b1;
            s_nxt.coll_cnt = 7'h00;
            s_nxt.defer_cnt = '0;
        end
        s_nxt.tx_aborted_flag = (s_r.tx_aborted_flag && !i_tx_ev.start) || i_tx_ev.abort;
        s_nxt.tx_fifo_underrun_flag = (s_r.tx_fifo_underrun_flag && !i_tx_ev.start) || i_tx_ev.underrun;
        s_nxt.carrier_lost_flag = (s_r.carrier_lost_flag && !i_tx_ev.start) || i_tx_ev.carrier_lost;
        s_nxt.tx_deferred_flag = (s_r.tx_deferred_flag && !i_tx_ev.start) || i_tx_ev.defer;
        s_nxt.late_collision_flag = (s_r.late_collision_flag && !i_tx_ev.start) || i_tx_ev.late_collision;
        if (i_tx_ev.collision && s_r.coll_cnt != desc_cmdsts_pkg::EXCESS_LIMIT_EXT) begin
            s_nxt.coll_cnt = i_tx_ev.start ? 7'h01 : cnt_inc;
        end
        // deferral length measured while the mac is held off
        if (i_tx_ev.defer && s_r.defer_cnt != LIMIT) begin
            s_nxt.defer_cnt = i_tx_ev.start ? {{(desc_cmdsts_pkg::DEFER_CNT_W-1){1'b0}}, 1'b1} :
                                              s_r.defer_cnt + 1'b1;
        end
        s_nxt.excess_deferral_flag = (s_r.excess_deferral_flag && !i_tx_ev.start) ||
                                     (i_tx_ev.defer && s_r.defer_cnt == LIMIT);

        // completion: build the cmdsts word, ownership and status together
        if (s_r.wb == desc_cmdsts_pkg::WB_IDLE && i_tx_ev.done) begin
            w = s_r.tx_cmd;
            w[desc_cmdsts_pkg::OWN_BIT] = 1'b0;
            if (!s_r.tx_cmd[desc_cmdsts_pkg::MORE_BIT]) begin
                w[26:16] = 11'h000;
                w[desc_cmdsts_pkg::ABORT_BIT] = s_nxt.tx_aborted_flag;
                w[desc_cmdsts_pkg::UNDERRUN_BIT] = s_nxt.tx_fifo_underrun_flag;
                w[desc_cmdsts_pkg::CARRIER_BIT] = s_nxt.carrier_lost_flag && !s_r.carrier_ignore;
                w[desc_cmdsts_pkg::DEFERRED_BIT] = s_nxt.tx_deferred_flag;
                w[desc_cmdsts_pkg::EXCESS_DEFER_BIT] = s_nxt.excess_deferral_flag;
                w[desc_cmdsts_pkg::LATE_COLL_BIT] = s_nxt.late_collision_flag;
                w[desc_cmdsts_pkg::EXCESS_COLL_BIT] = coll_excess(s_nxt.coll_cnt, s_r.extended_retry_mode);
                w[desc_cmdsts_pkg::TALLY_LSB+3:desc_cmdsts_pkg::TALLY_LSB] =
                    tally(s_nxt.coll_cnt, s_r.extended_retry_mode);
                w[desc_cmdsts_pkg::OK_BIT] = !w[desc_cmdsts_pkg::ABORT_BIT] &&
                                             !w[desc_cmdsts_pkg::EXCESS_COLL_BIT] &&
                                             !w[desc_cmdsts_pkg::EXCESS_DEFER_BIT];
            end
            w[15:12] = 4'h0;
            s_nxt.wb = desc_cmdsts_pkg::WB_PEND;
            s_nxt.wb_word = w;
            s_nxt.wb_is_tx = 1'b1;
            s_nxt.tx_active = 1'b0;
        end else if (s_r.wb == desc_cmdsts_pkg::WB_IDLE && i_rx_done) begin
            w = s_r.rx_cmd;
            w[desc_cmdsts_pkg::OWN_BIT] = 1'b1;
            w[desc_cmdsts_pkg::CRC_BIT] = 1'b1;
            w[26:16] = i_rx_status;
            w[15:12] = 4'h0;
            w[desc_cmdsts_pkg::SIZE_W-1:0] = i_rx_size;
            s_nxt.wb = desc_cmdsts_pkg::WB_PEND;
            s_nxt.wb_word = w;
            s_nxt.wb_is_tx = 1'b0;
        end

        // write-back accepted: ownership is back with the other side
        if (s_r.wb == desc_cmdsts_pkg::WB_PEND && i_wb_ready) begin
            s_nxt.wb = desc_cmdsts_pkg::WB_IDLE;
            s_nxt.last_wb = s_r.wb_word;
            s_nxt.irq = s_r.wb_word[desc_cmdsts_pkg::IRQ_REQ_BIT];
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            s_r <= '0;
            s_r.wb <= desc_cmdsts_pkg::WB_IDLE;
            {s_r.carrier_ignore, s_r.extended_retry_mode, s_r.legacy_layout_select} <= desc_cmdsts_pkg::CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    // a deferral seen, then completion accepted next cycle
    sequence seq_defer_done;
        (i_tx_ev.defer && !i_tx_ev.start) ##1 (i_tx_ev.done && o_tx_done_ready);
    endsequence

    // a write-back handshake with an interrupt request in it
    sequence seq_wb_irq;
        o_wb_valid && i_wb_ready && o_wb_word[desc_cmdsts_pkg::IRQ_REQ_BIT];
    endsequence

    chk_legacy_bufptr: assert property (i_desc_valid && s_r.legacy_layout_select && !wr_ctrl()
        |=> o_fetch.valid && o_fetch.buf_ptr == $past(i_desc.word3))
        else $error("legacy pointer not taken from the third word");
    chk_byte_count: assert property (i_desc_valid
        |=> o_fetch.byte_count == $past(i_desc.cmdsts[11:0]))
        else $error("byte count not taken from low bits");
    chk_crc_inhibit: assert property (i_desc_valid && i_desc.is_tx
        |=> o_fetch.crc_append_inhibit == $past(i_desc.cmdsts[desc_cmdsts_pkg::CRC_BIT]))
        else $error("crc inhibit does not follow bit 28");
    chk_tx_own_return: assert property (o_wb_valid && o_wb_is_tx
        |-> !o_wb_word[desc_cmdsts_pkg::OWN_BIT])
        else $error("transmit write-back keeps ownership");
    chk_rx_own_crc: assert property (o_wb_valid && !o_wb_is_tx
        |-> o_wb_word[desc_cmdsts_pkg::OWN_BIT] && o_wb_word[desc_cmdsts_pkg::CRC_BIT])
        else $error("receive write-back lacks ownership or crc bit");
    chk_irq_return: assert property (seq_wb_irq |=> o_desc_irq ##1 !o_desc_irq)
        else $error("descriptor interrupt not one pulse after return");
    chk_no_spurious_irq: assert property (o_desc_irq |-> $past(o_wb_valid && i_wb_ready))
        else $error("descriptor interrupt without ownership return");
    chk_carrier_mask: assert property (o_wb_valid && o_wb_is_tx && s_r.carrier_ignore
        |-> !o_wb_word[desc_cmdsts_pkg::CARRIER_BIT])
        else $error("carrier loss reported while ignored");
    chk_deferred: assert property (seq_defer_done
        |=> !s_r.tx_cmd[desc_cmdsts_pkg::MORE_BIT] -> o_wb_word[desc_cmdsts_pkg::DEFERRED_BIT])
        else $error("deferral not reported");
    chk_excess_std: assert property (i_tx_ev.done && o_tx_done_ready && !s_r.extended_retry_mode
        && !s_r.tx_cmd[desc_cmdsts_pkg::MORE_BIT] && !i_tx_ev.collision && !i_tx_ev.start
        |=> o_wb_word[desc_cmdsts_pkg::EXCESS_COLL_BIT] == ($past(s_r.coll_cnt) >= 7'h10))
        else $error("excessive collision bit wrong at 16");
    chk_wb_hold: assert property (o_wb_valid && !i_wb_ready |=> o_wb_valid && $stable(o_wb_word))
        else $error("write-back word changed before acceptance");

    // control register write in flight: always 0, the decode reads the registered layout choice
    function automatic logic wr_ctrl();
        wr_ctrl = 1'b0;
    endfunction

endmodule

// ===== test/host_mem_model.sv
// host memory stand-in that takes descriptor write-backs after a chosen stall
`timescale 1ns/1ps
module host_mem_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // write-back request from the block
    input wire logic i_valid,
    input wire logic [31:0] i_word,
    input wire logic [3:0] i_stall,
    // handshake and captured word
    output logic o_ready,
    output logic [31:0] o_word,
    output logic o_took
);
    // ------------------------------------------------------------
    // acceptor
    // ------------------------------------------------------------
    logic [3:0] wait_r;
    // hold off ready for the stall, then take the whole word in one go
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wait_r <= 4'h0;
            o_ready <= 1'b0;
            o_word <= 32'h0000_0000;
            o_took <= 1'b0;
        end else begin
            o_took <= i_valid & o_ready;
            if (i_valid & o_ready) begin
                o_word <= i_word;
                o_ready <= 1'b0;
                wait_r <= 4'h0;
            end else if (i_valid & (wait_r >= i_stall)) begin
                o_ready <= 1'b1;
            end else if (i_valid) begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// ===== test/testbench.sv
// self-checking bench for the descriptor command/status block
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic i_clock, i_nrst, desc_valid, rx_done, wb_valid, wb_ready, desc_irq, took;
    desc_cmdsts_pkg::apb_req_t apb;
    desc_cmdsts_pkg::apb_rsp_t rsp;
    desc_cmdsts_pkg::desc_in_t desc;
    desc_cmdsts_pkg::desc_info_t fetch;
    desc_cmdsts_pkg::tx_event_t ev;
    logic [10:0] rx_status;
    logic [11:0] rx_size;
    logic [31:0] wb_word, cap_word;
    logic [3:0] stall;
    int errors, n_tests, n_irq;
    desc_cmdsts #(.DEFER_LIMIT(20)) i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_apb(apb), .o_apb(rsp),
        .i_desc_valid(desc_valid), .i_desc(desc), .o_fetch(fetch), .i_tx_ev(ev), .o_tx_done_ready(),
        .i_rx_done(rx_done), .i_rx_status(rx_status), .i_rx_size(rx_size), .o_rx_done_ready(),
        .o_wb_valid(wb_valid), .o_wb_is_tx(), .o_wb_word(wb_word), .i_wb_ready(wb_ready), .o_desc_irq(desc_irq));
    host_mem_model i_host (.i_clock(i_clock), .i_nrst(i_nrst), .i_valid(wb_valid), .i_word(wb_word),
        .i_stall(stall), .o_ready(wb_ready), .o_word(cap_word), .o_took(took));
    // clock and interrupt pulse tally
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(posedge i_clock) if (desc_irq === 1'b1) n_irq++;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                            output logic e);
        int k;
        apb <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
        @(posedge i_clock);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        q = rsp.prdata;
        e = rsp.pslverr;
        apb <= '0;
        if (k >= 50) begin
            errors++;
            test_done();
        end
        // one idle edge so the next setup is never a second assignment in this step
        @(posedge i_clock);
    endtask
    task automatic wait_wb(output logic [31:0] w);
        int k;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (took !== 1'b1 && k < 200);
        w = cap_word;
        if (k >= 200) begin
            errors++;
            test_done();
        end
    endtask
    // expected transmit write-back: ownership back, status and ok filled, reserved cleared
    function automatic logic [31:0] tx_exp(input logic [31:0] c, input logic [10:0] s);
        return {1'b0, c[30:28], !(s[10] | s[6] | s[4]), s, 4'h0, c[11:0]};
    endfunction
    task automatic tx_pkt(input int nc, input int nd, input logic [7:0] x, output logic [31:0] w);
        ev <= desc_cmdsts_pkg::tx_event_t'(x | 8'h80);
        for (int k = 0; k < nc + nd; k++) begin
            @(posedge i_clock);
            ev <= desc_cmdsts_pkg::tx_event_t'((k < nc) ? 8'h20 : 8'h10);
        end
        @(posedge i_clock);
        ev <= desc_cmdsts_pkg::tx_event_t'(8'h40);
        @(posedge i_clock);
        ev <= '0;
        wait_wb(w);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_fetch(input logic [31:0] cfg, input logic tx, input logic [31:0] c, input logic [5:0] fl,
                           input logic [31:0] ptr);
        logic [31:0] q, f;
        logic e;
        apb_xfer(1'b1, desc_cmdsts_pkg::CTRL_OFFSET, cfg, q, e);
        desc_valid <= 1'b1;
        desc <= '{is_tx:tx, cmdsts:c, word2:32'h1111_0008, word3:32'h2222_000C};
        @(posedge i_clock);
        desc_valid <= 1'b0;
        @(negedge i_clock);
        f = {26'h0, fetch.valid, fetch.is_tx, fetch.owned, fetch.last, fetch.descriptor_irq_request, 1'b0};
        f[0] = fetch.crc_append_inhibit;
        chk(f, {26'h0, fl});
        chk({20'h0, fetch.byte_count}, {20'h0, c[11:0]});
        chk(fetch.buf_ptr, ptr);
        @(posedge i_clock);
    endtask
    task automatic t_tx();
        logic [31:0] cfg[5] = '{32'h0, 32'h0, 32'h2, 32'h4, 32'h0};
        int nc[5] = '{3, 16, 33, 0, 1};
        int nd[5] = '{2, 0, 0, 25, 0};
        logic [7:0] xe[5] = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h0B};
        logic [10:0] st[5] = '{11'h183, 11'h010, 11'h009, 11'h0C0, 11'h621};
        logic [31:0] q, w;
        logic e;
        int i0;
        t_fetch(32'h0, 1'b1, 32'hA000_0040, 6'b111110, 32'h1111_0008);
        i0 = n_irq;
        for (int r = 0; r < 5; r++) begin
            apb_xfer(1'b1, desc_cmdsts_pkg::CTRL_OFFSET, cfg[r], q, e);
            stall <= r[3:0];
            tx_pkt(nc[r], nd[r], xe[r], w);
            chk(w, tx_exp(32'hA000_0040, st[r]));
        end
        @(posedge i_clock);
        chk(n_irq - i0, 5);
    endtask
    task automatic t_rx();
        logic [31:0] w;
        t_fetch(32'h0, 1'b0, 32'h0000_0000, 6'b101100, 32'h1111_0008);
        rx_status <= 11'h5A5;
        rx_size <= 12'h123;
        rx_done <= 1'b1;
        @(posedge i_clock);
        rx_done <= 1'b0;
        wait_wb(w);
        chk(w, 32'h95A5_0123);
    endtask
    task automatic t_apb();
        logic [31:0] q;
        logic e;
        apb_xfer(1'b1, desc_cmdsts_pkg::CTRL_OFFSET, 32'h0000_0007, q, e);
        apb_xfer(1'b0, desc_cmdsts_pkg::CTRL_OFFSET, 32'h0000_0000, q, e);
        chk(q, 32'h0000_0007);
        chk({31'h0, e}, 32'h0000_0000);
        apb_xfer(1'b0, 8'h40, 32'h0000_0000, q, e);
        chk({q, e} == {32'h0, 1'b1}, 32'h0000_0001);
        // last write-back word, from the receive packet, and sticky status of the final transmit packet
        apb_xfer(1'b0, desc_cmdsts_pkg::LAST_WB_OFFSET, 32'h0000_0000, q, e);
        chk(q, 32'h95A5_0123);
        apb_xfer(1'b0, desc_cmdsts_pkg::STATUS_OFFSET, 32'h0000_0000, q, e);
        chk(q, 32'h0000_3101);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        n_tests = 0;
        n_irq = 0;
        i_nrst = 1'b0;
        apb = '0;
        desc = '0;
        desc_valid = 1'b0;
        ev = '0;
        rx_done = 1'b0;
        rx_status = 11'h000;
        rx_size = 12'h000;
        stall = 4'h0;
        repeat (4) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        t_fetch(32'h0, 1'b1, 32'hB000_0ABC, 6'b111111, 32'h1111_0008);
        t_fetch(32'h1, 1'b0, 32'h5000_0010, 6'b101000, 32'h2222_000C);
        t_tx();
        t_rx();
        t_apb();
        test_done();
    end
endmodule
